// file: fsr_defines.svh
// Constants for the flash status register logic: opcodes, bit positions, reset values, geometry
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

// Status word bit positions
`define FSR_BIT_BUSY 0
`define FSR_BIT_LATCH 1
`define FSR_BIT_BP_LO 2
`define FSR_BIT_BP_HI 5
`define FSR_BIT_QUAD 6
`define FSR_BIT_LOCK 7
`define FSR_STATUS_RESET 8'h00
`define FSR_BP_NONE 4'h0

// Instruction codes
`define FSR_OP_SET_LATCH 8'h06
`define FSR_OP_CLR_LATCH 8'h04
`define FSR_OP_STATUS_WRITE 8'h01
`define FSR_OP_STATUS_READ 8'h05
`define FSR_OP_FUNC_READ 8'h48
`define FSR_OP_EXT_READ 8'h81
`define FSR_OP_ERASE_ALL_A 8'hC7
`define FSR_OP_ERASE_ALL_B 8'h60
`define FSR_OP_PROGRAM_A 8'h02
`define FSR_OP_PROGRAM_B 8'h32
`define FSR_OP_SECTOR_ERASE_A 8'h20
`define FSR_OP_SECTOR_ERASE_B 8'hD7
`define FSR_OP_BLOCK32_ERASE 8'h52
`define FSR_OP_BLOCK64_ERASE 8'hD8
`define FSR_OP_SW_RESET_A 8'h66
`define FSR_OP_SW_RESET_B 8'h99
`define FSR_OP_SUSPEND_A 8'h75
`define FSR_OP_SUSPEND_B 8'hB0
`define FSR_OP_RESUME_A 8'h7A
`define FSR_OP_RESUME_B 8'h30

// Array geometry: 32 Mbyte in 4 Kbyte sectors
`define FSR_ADDR_W 25
`define FSR_SECTOR_SHIFT 12
`define FSR_SECTOR_W 13
`define FSR_WORD_BITS 3'h7

`endif

// file: fsr_pkg.sv
// Types shared by the flash status register logic
package fsr_pkg;

    // Gray order along idle -> run -> suspended
    typedef enum logic [1:0] {
        FSR_IDLE = 2'h0,
        FSR_RUN = 2'h1,
        FSR_SUSP = 2'h3
    } fsr_state_t;

    typedef enum logic [2:0] {
        FSR_K_NONE = 3'h0,
        FSR_K_PROGRAM = 3'h1,
        FSR_K_SECTOR_ERASE = 3'h2,
        FSR_K_BLOCK32_ERASE = 3'h3,
        FSR_K_BLOCK64_ERASE = 3'h4,
        FSR_K_CHIP_ERASE = 3'h5,
        FSR_K_STATUS_WRITE = 3'h6
    } fsr_kind_t;

endpackage

// file: fsr_shift_out.sv
// Serial shifter that sends the status word MSB first, repeating while selected
`timescale 1ns/1ps
`include "fsr_defines.svh"

module fsr_shift_out (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_en,
    // Control
    input wire logic load,
    input wire logic shift,
    input wire logic deselect,
    input wire logic [7:0] word,
    // Serial output
    output logic bit_q,
    output logic active_q
);
    logic [7:0] sh_q;
    logic [2:0] cnt_q;
    wire wrap = (cnt_q == `FSR_WORD_BITS);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sh_q <= 8'h00;
            cnt_q <= 3'h0;
            bit_q <= 1'b0;
            active_q <= 1'b0;
        end else if (clock_en) begin
            if (deselect) begin
                active_q <= 1'b0;
            end else if (load || (shift && active_q && wrap)) begin
                // Reload current word so a changing busy bit is seen
                sh_q <= word;
                cnt_q <= 3'h0;
                bit_q <= word[7];
                active_q <= 1'b1;
            end else if (shift && active_q) begin
                sh_q <= {sh_q[6:0], 1'b0};
                cnt_q <= cnt_q + 3'h1;
                bit_q <= sh_q[6];
            end
        end
    end
endmodule

// file: fsr_status_reg.sv
// Status register logic: busy flag, write permit latch, protection and quad bits
`timescale 1ns/1ps
`include "fsr_defines.svh"

module fsr_status_reg (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_en,
    // Decoded instruction
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_data,
    input wire logic [`FSR_ADDR_W-1:0] cmd_addr,
    // Pins and serial read
    input wire logic write_protect_n,
    input wire logic select_n,
    input wire logic shift_en,
    // Array engine
    input wire logic op_done,
    // Status outputs
    output logic [7:0] status_word_q,
    output logic serial_out_q,
    output logic serial_active_q,
    // Operation control
    output logic op_start_q,
    output fsr_pkg::fsr_kind_t op_kind_q,
    output logic [`FSR_SECTOR_W-1:0] op_sector_q,
    output logic op_suspended_q,
    output logic op_abort_q,
    output logic cmd_ignored_q
);
    fsr_pkg::fsr_state_t state_q;
    fsr_pkg::fsr_state_t state_d;
    logic [7:0] status_d;
    fsr_pkg::fsr_kind_t kind_d;

    // Decode
    wire take = cmd_valid && clock_en;
    wire is_set_latch = (cmd_code == `FSR_OP_SET_LATCH);
    wire is_clr_latch = (cmd_code == `FSR_OP_CLR_LATCH);
    wire is_st_write = (cmd_code == `FSR_OP_STATUS_WRITE);
    wire is_st_read = (cmd_code == `FSR_OP_STATUS_READ);
    wire is_reg_read = is_st_read || (cmd_code == `FSR_OP_FUNC_READ) || (cmd_code == `FSR_OP_EXT_READ);
    wire is_erase_all = (cmd_code == `FSR_OP_ERASE_ALL_A) || (cmd_code == `FSR_OP_ERASE_ALL_B);
    wire is_program = (cmd_code == `FSR_OP_PROGRAM_A) || (cmd_code == `FSR_OP_PROGRAM_B);
    wire is_sec_erase = (cmd_code == `FSR_OP_SECTOR_ERASE_A) || (cmd_code == `FSR_OP_SECTOR_ERASE_B);
    wire is_b32_erase = (cmd_code == `FSR_OP_BLOCK32_ERASE);
    wire is_b64_erase = (cmd_code == `FSR_OP_BLOCK64_ERASE);
    wire is_sw_reset = (cmd_code == `FSR_OP_SW_RESET_A) || (cmd_code == `FSR_OP_SW_RESET_B);
    wire is_suspend = (cmd_code == `FSR_OP_SUSPEND_A) || (cmd_code == `FSR_OP_SUSPEND_B);
    wire is_resume = (cmd_code == `FSR_OP_RESUME_A) || (cmd_code == `FSR_OP_RESUME_B);

    wire idle = (state_q == fsr_pkg::FSR_IDLE);
    wire running = (state_q == fsr_pkg::FSR_RUN);
    wire latch = status_word_q[`FSR_BIT_LATCH];
    wire lock = status_word_q[`FSR_BIT_LOCK];
    wire [3:0] protect = status_word_q[`FSR_BIT_BP_HI:`FSR_BIT_BP_LO];
    wire array_op = (op_kind_q != fsr_pkg::FSR_K_STATUS_WRITE);

    wire st_locked = lock && !write_protect_n;
    wire erase_ok = (protect == `FSR_BP_NONE);
    wire wr_class = is_program || is_sec_erase || is_b32_erase || is_b64_erase || is_erase_all || is_st_write;
    wire wr_allowed = is_program || is_sec_erase || is_b32_erase || is_b64_erase
                    || (is_erase_all && erase_ok) || (is_st_write && !st_locked);
    wire start_wr = take && idle && latch && wr_allowed;
    wire do_set = take && idle && is_set_latch;
    wire do_clr = take && idle && is_clr_latch;
    wire do_reset = take && is_sw_reset;
    wire do_suspend = take && running && is_suspend && array_op;
    wire do_resume = take && (state_q == fsr_pkg::FSR_SUSP) && is_resume;
    wire finish = clock_en && running && op_done;
    wire do_read = take && is_st_read && !select_n;
    wire accepted = start_wr || do_set || do_clr || do_reset || do_suspend || do_resume || (take && is_reg_read);
    wire ignored = take && !accepted;

    // Kind of write-class operation
    always_comb begin
        kind_d = fsr_pkg::FSR_K_NONE;
        if (is_program) begin
            kind_d = fsr_pkg::FSR_K_PROGRAM;
        end else if (is_sec_erase) begin
            kind_d = fsr_pkg::FSR_K_SECTOR_ERASE;
        end else if (is_b32_erase) begin
            kind_d = fsr_pkg::FSR_K_BLOCK32_ERASE;
        end else if (is_b64_erase) begin
            kind_d = fsr_pkg::FSR_K_BLOCK64_ERASE;
        end else if (is_erase_all) begin
            kind_d = fsr_pkg::FSR_K_CHIP_ERASE;
        end else if (is_st_write) begin
            kind_d = fsr_pkg::FSR_K_STATUS_WRITE;
        end
    end

    // Operation sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            fsr_pkg::FSR_IDLE: begin
                if (start_wr) begin
                    state_d = fsr_pkg::FSR_RUN;
                end
            end
            fsr_pkg::FSR_RUN: begin
                if (do_reset || finish) begin
                    state_d = fsr_pkg::FSR_IDLE;
                end else if (do_suspend) begin
                    state_d = fsr_pkg::FSR_SUSP;
                end
            end
            fsr_pkg::FSR_SUSP: begin
                if (do_reset) begin
                    state_d = fsr_pkg::FSR_IDLE;
                end else if (do_resume) begin
                    state_d = fsr_pkg::FSR_RUN;
                end
            end
            default: begin
                state_d = fsr_pkg::FSR_IDLE;
            end
        endcase
    end

    // Next status word
    always_comb begin
        status_d = status_word_q;
        status_d[`FSR_BIT_BUSY] = (state_d == fsr_pkg::FSR_RUN);
        if (start_wr && is_st_write) begin
            // Latch bit is not taken from the written data
            status_d[7:2] = cmd_data[7:2];
        end
        if (do_clr || finish || do_reset) begin
            status_d[`FSR_BIT_LATCH] = 1'b0;
        end
        if (do_set) begin
            status_d[`FSR_BIT_LATCH] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= fsr_pkg::FSR_IDLE;
            status_word_q <= `FSR_STATUS_RESET;
            op_start_q <= 1'b0;
            op_kind_q <= fsr_pkg::FSR_K_NONE;
            op_sector_q <= '0;
            op_suspended_q <= 1'b0;
            op_abort_q <= 1'b0;
            cmd_ignored_q <= 1'b0;
        end else if (clock_en) begin
            state_q <= state_d;
            status_word_q <= status_d;
            op_start_q <= start_wr;
            op_suspended_q <= (state_d == fsr_pkg::FSR_SUSP);
            op_abort_q <= do_reset && !idle;
            cmd_ignored_q <= ignored;
            if (start_wr) begin
                op_kind_q <= kind_d;
                op_sector_q <= cmd_addr[`FSR_ADDR_W-1:`FSR_SECTOR_SHIFT];
            end
        end
    end

    fsr_shift_out u_shift (
        .clock(clock),
        .reset_n(reset_n),
        .clock_en(clock_en),
        .load(do_read),
        .shift(shift_en),
        .deselect(select_n),
        .word(status_word_q),
        .bit_q(serial_out_q),
        .active_q(serial_active_q)
    );

    a_latch_gates_write: assert property (@(posedge clock) disable iff (!reset_n)
        take && idle && !latch |=> !op_start_q) else $error("write started without latch");
    a_busy_ignores_set: assert property (@(posedge clock) disable iff (!reset_n)
        take && running && (is_set_latch || is_clr_latch) && !op_done |=> $stable(status_word_q[1]))
        else $error("latch moved while busy");
    a_done_clears_busy: assert property (@(posedge clock) disable iff (!reset_n)
        finish |=> !status_word_q[0] && !status_word_q[1] && idle) else $error("finish left busy or latch");
    a_busy_matches_run: assert property (@(posedge clock) disable iff (!reset_n)
        status_word_q[0] == running) else $error("busy flag disagrees with state");
    a_status_write_keeps: assert property (@(posedge clock) disable iff (!reset_n)
        start_wr && is_st_write |=> status_word_q[1] && status_word_q[7:2] == $past(cmd_data[7:2]))
        else $error("status write wrong");
    a_lock_blocks_write: assert property (@(posedge clock) disable iff (!reset_n)
        take && is_st_write && st_locked |=> $stable(status_word_q[7:2])) else $error("locked bits changed");
    a_erase_needs_clear: assert property (@(posedge clock) disable iff (!reset_n)
        take && is_erase_all && !erase_ok |=> !op_start_q) else $error("erase ran with protection");
    a_set_latch_works: assert property (@(posedge clock) disable iff (!reset_n)
        do_set |=> status_word_q[1] ##1 (status_word_q[1] || $past(take))) else $error("latch not set");
    a_start_goes_busy: assert property (@(posedge clock) disable iff (!reset_n)
        start_wr |=> op_start_q && status_word_q[0] ##1 !op_start_q || !clock_en) else $error("start pulse wrong");
    a_nv_only_by_write: assert property (@(posedge clock) disable iff (!reset_n)
        !(start_wr && is_st_write) |=> $stable(status_word_q[7:2])) else $error("nv bits changed");

    a_refuse_no_latch: assert property (@(posedge clock) disable iff (!reset_n)
        take && idle && !latch && wr_class |=> cmd_ignored_q) else $error("unlatched write not refused");
    a_reset_aborts_op: assert property (@(posedge clock) disable iff (!reset_n)
        do_reset && !idle |=> op_abort_q && !status_word_q[0] && !status_word_q[1])
        else $error("software reset left op running");
endmodule

// file: fsr_host_model.sv
// Host controller model that offers instructions and clocks status reads
`timescale 1ns/1ps
`include "fsr_defines.svh"

module fsr_host_model (
    // Clock
    input wire logic clock,
    // Instruction and read control
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_data,
    output logic [`FSR_ADDR_W-1:0] cmd_addr,
    output logic select_n,
    output logic shift_en
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_data = 8'h00;
        cmd_addr = '0;
        select_n = 1'b1;
        shift_en = 1'b0;
    end

    task automatic issue(input logic [7:0] c, input logic [7:0] d, input logic [`FSR_ADDR_W-1:0] a);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_data <= d;
        cmd_addr <= a;
        @(posedge clock);
        cmd_valid <= 1'b0;
        // Released lines must not keep showing the last value
        cmd_code <= ~c;
        cmd_data <= ~d;
        cmd_addr <= ~a;
        #1;
    endtask

    task automatic write_op(input logic [7:0] c, input logic [7:0] d, input logic [`FSR_ADDR_W-1:0] a);
        issue(`FSR_OP_SET_LATCH, 8'h00, '0);
        issue(c, d, a);
    endtask

    task automatic shift();
        @(posedge clock);
        shift_en <= 1'b1;
        @(posedge clock);
        shift_en <= 1'b0;
        #1;
    endtask

    task automatic select(input logic s);
        @(posedge clock);
        select_n <= s;
        #1;
    endtask
endmodule

// file: fsr_status_reg_tb.sv
// Self-checking testbench for the flash status register logic
`timescale 1ns/1ps
`include "fsr_defines.svh"

module fsr_status_reg_tb;
    logic clock, reset_n, clock_en, write_protect_n, op_done;
    logic cmd_valid, select_n, shift_en;
    logic [7:0] cmd_code, cmd_data, sw, w, d;
    logic [`FSR_ADDR_W-1:0] cmd_addr, a;
    logic [31:0] rnd;
    logic ser, act, start, susp, abrt, ign;
    fsr_pkg::fsr_kind_t kind;
    logic [`FSR_SECTOR_W-1:0] sect;
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 83186;
    logic [7:0] ops [6] = '{`FSR_OP_PROGRAM_A, `FSR_OP_PROGRAM_B, `FSR_OP_SECTOR_ERASE_A,
        `FSR_OP_SECTOR_ERASE_B, `FSR_OP_BLOCK32_ERASE, `FSR_OP_BLOCK64_ERASE};

    fsr_host_model u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .cmd_addr(cmd_addr), .select_n(select_n), .shift_en(shift_en));

    fsr_status_reg u_dut (.clock(clock), .reset_n(reset_n), .clock_en(clock_en),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_addr(cmd_addr),
        .write_protect_n(write_protect_n), .select_n(select_n), .shift_en(shift_en),
        .op_done(op_done), .status_word_q(sw), .serial_out_q(ser), .serial_active_q(act),
        .op_start_q(start), .op_kind_q(kind), .op_sector_q(sect), .op_suspended_q(susp),
        .op_abort_q(abrt), .cmd_ignored_q(ign));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function automatic fsr_pkg::fsr_kind_t exp_kind(input logic [7:0] c);
        case (c)
            `FSR_OP_PROGRAM_A, `FSR_OP_PROGRAM_B: exp_kind = fsr_pkg::FSR_K_PROGRAM;
            `FSR_OP_SECTOR_ERASE_A, `FSR_OP_SECTOR_ERASE_B: exp_kind = fsr_pkg::FSR_K_SECTOR_ERASE;
            `FSR_OP_BLOCK32_ERASE: exp_kind = fsr_pkg::FSR_K_BLOCK32_ERASE;
            default: exp_kind = fsr_pkg::FSR_K_BLOCK64_ERASE;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_op();
        @(posedge clock);
        op_done <= 1'b1;
        @(posedge clock);
        op_done <= 1'b0;
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        reset_n = 1'b0;
        clock_en = 1'b1;
        write_protect_n = 1'b1;
        op_done = 1'b0;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        #1;
        chk("status", 16'h0000, sw);
        chk("kind", fsr_pkg::FSR_K_NONE, kind);
        u_host.issue(`FSR_OP_PROGRAM_A, 8'h00, '0);
        chk("ignored", 16'h0001, ign);
        chk("start", 16'h0000, start);
        u_host.issue(`FSR_OP_SET_LATCH, 8'h00, '0);
        chk("status", 16'h0002, sw);
        u_host.issue(`FSR_OP_CLR_LATCH, 8'h00, '0);
        chk("status", 16'h0000, sw);
        $display("latch test done");
        for (int i = 0; i < 6; i++) begin
            rnd = $random(seed);
            a = rnd[`FSR_ADDR_W-1:0];
            u_host.write_op(ops[i], 8'h00, a);
            chk("start", 16'h0001, start);
            chk("kind", exp_kind(ops[i]), kind);
            chk("sector", {3'h0, a[24:12]}, sect);
            chk("status", 16'h0003, sw);
            u_host.issue(`FSR_OP_CLR_LATCH, 8'h00, '0);
            chk("ignored", 16'h0001, ign);
            u_host.issue(`FSR_OP_STATUS_READ, 8'h00, '0);
            chk("ignored", 16'h0000, ign);
            finish_op();
            chk("status", 16'h0000, sw);
        end
        $display("operation test done");
        rnd = $random(seed);
        d = (rnd[7:0] & 8'h7C) | 8'h04;
        u_host.write_op(`FSR_OP_STATUS_WRITE, d, '0);
        chk("status", {d[7:2], 2'h3}, sw);
        finish_op();
        chk("status", {d[7:2], 2'h0}, sw);
        u_host.write_op(`FSR_OP_ERASE_ALL_A, 8'h00, '0);
        chk("ignored", 16'h0001, ign);
        u_host.issue(`FSR_OP_CLR_LATCH, 8'h00, '0);
        w = {d[7:2], 2'h0};
        u_host.select(1'b0);
        u_host.issue(`FSR_OP_STATUS_READ, 8'h00, '0);
        chk("active", 16'h0001, act);
        for (int k = 0; k < 8; k++) begin
            chk("serial", w[7-k], ser);
            u_host.shift();
        end
        chk("serial", w[7], ser);
        u_host.select(1'b1);
        @(posedge clock);
        #1;
        chk("active", 16'h0000, act);
        $display("read test done");
        u_host.write_op(`FSR_OP_STATUS_WRITE, 8'h80, '0);
        finish_op();
        u_host.write_op(`FSR_OP_ERASE_ALL_B, 8'h00, '0);
        chk("kind", fsr_pkg::FSR_K_CHIP_ERASE, kind);
        finish_op();
        write_protect_n <= 1'b0;
        u_host.write_op(`FSR_OP_STATUS_WRITE, 8'h3C, '0);
        chk("ignored", 16'h0001, ign);
        chk("bits", 16'h0020, sw[7:2]);
        write_protect_n <= 1'b1;
        u_host.write_op(`FSR_OP_STATUS_WRITE, 8'h00, '0);
        finish_op();
        chk("status", 16'h0000, sw);
        $display("protect test done");
        u_host.write_op(`FSR_OP_PROGRAM_B, 8'h00, a);
        u_host.issue(`FSR_OP_SUSPEND_A, 8'h00, '0);
        chk("suspended", 16'h0001, susp);
        chk("status", 16'h0002, sw);
        u_host.issue(`FSR_OP_PROGRAM_A, 8'h00, a);
        chk("ignored", 16'h0001, ign);
        chk("start", 16'h0000, start);
        u_host.issue(`FSR_OP_EXT_READ, 8'h00, '0);
        chk("ignored", 16'h0000, ign);
        u_host.issue(`FSR_OP_RESUME_B, 8'h00, '0);
        chk("suspended", 16'h0000, susp);
        chk("status", 16'h0003, sw);
        u_host.issue(`FSR_OP_FUNC_READ, 8'h00, '0);
        chk("ignored", 16'h0000, ign);
        u_host.issue(`FSR_OP_SW_RESET_B, 8'h00, '0);
        chk("abort", 16'h0001, abrt);
        chk("status", 16'h0000, sw);
        u_host.write_op(`FSR_OP_STATUS_WRITE, 8'h00, '0);
        u_host.issue(`FSR_OP_SUSPEND_B, 8'h00, '0);
        chk("ignored", 16'h0001, ign);
        chk("suspended", 16'h0000, susp);
        finish_op();
        chk("status", 16'h0000, sw);
        u_host.issue(`FSR_OP_SET_LATCH, 8'h00, '0);
        u_host.issue(`FSR_OP_SW_RESET_A, 8'h00, '0);
        chk("abort", 16'h0000, abrt);
        chk("status", 16'h0000, sw);
        @(posedge clock);
        clock_en <= 1'b0;
        u_host.issue(`FSR_OP_SET_LATCH, 8'h00, '0);
        chk("ignored", 16'h0000, ign);
        chk("status", 16'h0000, sw);
        clock_en <= 1'b1;
        $display("suspend test done");
        conclude();
    end
endmodule
